// file: include/lsip_pkg.sv
// Constants for the sample input port receive logic
// Overview of operation
// - Interface mode bit 0 clear selects word mode using all sixteen lines
// - Interface mode bit 0 set selects byte mode; upper eight lines ignored, lower eight when bit 5 is set
// - Word mode: in-phase after rising, quadrature after falling clock edge
// - Byte order is I high, I low, Q high, Q low; reassembled so
// - Frame rising edge marks the in-phase high byte; counter aligns to it
// - Single or repeating frame accepted; first captured rise aligns bytes
// - Config bit 7 picks offset binary or two's complement input samples
// - Config bit 6 picks how I and Q words group into pairs
// - Config bit 5 reverses bus bit order, line 15 becomes bit 0
// - Four delay settings from tap and trim register value pairs
// - Trim bit 3 enables the clock delay line, else it is bypassed
// - Samples are latched, reformatted, then written to the FIFO slot
package lsip_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 15;
    localparam logic [14:0] ADDR_CFG      = 15'h0026;
    localparam logic [14:0] ADDR_TAPS     = 15'h005E;
    localparam logic [14:0] ADDR_TRIM     = 15'h005F;
    localparam logic [14:0] ADDR_SETUP    = 15'h0079;
    localparam logic [7:0]  RST_CFG       = 8'h00;
    localparam logic [7:0]  RST_TAPS      = 8'h00;
    localparam logic [7:0]  RST_TRIM      = 8'h00;
    localparam logic [7:0]  RST_SETUP     = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          CFG_BYTE_BIT  = 0;
    localparam int          CFG_INV_BIT   = 5;
    localparam int          CFG_PAIR_BIT  = 6;
    localparam int          CFG_FMT_BIT   = 7;
    localparam int          TRIM_EN_BIT   = 3;

    // ------------------------------------------------------------------
    // Delay settings
    // ------------------------------------------------------------------
    localparam logic [7:0]  TAPS_SET0     = 8'h00;
    localparam logic [7:0]  TAPS_SET1     = 8'h07;
    localparam logic [7:0]  TAPS_SET2     = 8'h7F;
    localparam logic [7:0]  TAPS_SET3     = 8'hFF;
    localparam logic [2:0]  TRIM_SET012   = 3'h0;
    localparam logic [2:0]  TRIM_SET3     = 3'h5;

    // ------------------------------------------------------------------
    // Timing, in picoseconds and in clk_sys cycles
    // ------------------------------------------------------------------
    localparam int CLK_PS       = 8000;
    localparam int FIX_DLY_PS   = 1900;
    localparam int TAP_DLY_PS   = 300;
    localparam int FIX_DLY_CYC  = (FIX_DLY_PS + CLK_PS - 1) / CLK_PS;
    localparam int TAP_DLY_CYC  = (TAP_DLY_PS + CLK_PS - 1) / CLK_PS;
    localparam int DLY_MAX_CYC  = FIX_DLY_CYC + 3 * TAP_DLY_CYC;

    // ------------------------------------------------------------------
    // Byte sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BYTE_I_HI,
        BYTE_I_LO,
        BYTE_Q_HI,
        BYTE_Q_LO
    } lsip_byte_t;

endpackage

// file: verilog/lsip_fifo.sv
// Sample pair FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lsip_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
            $error("lsip_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;

    wire  do_wr = in_valid & in_ready;
    wire  do_rd = out_valid & out_ready;
    wire  empty = (wr_ptr_ff == rd_ptr_ff);
    wire  full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                  (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_wr)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (do_rd)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // Slot chosen by the write pointer
    always_ff @(posedge clk_sys) begin
        if (do_wr)
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end

endmodule
`default_nettype wire

// file: verilog/lsip_port.sv
// Receive side of the source-synchronous I/Q sample input port
`timescale 1ns/1ps
`default_nettype none
module lsip_port #(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [15:0] sample_bus_lines,
    input  wire logic        frame_in,
    input  wire logic        forwarded_data_clock,
    input  wire logic [14:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [15:0]      out_i,
    output logic [15:0]      out_q,
    output logic             frame_aligned,
    output logic             pair_dropped,
    output logic [1:0]       delay_setting
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] rev16(input logic [15:0] d);
        logic [15:0] r;
        r = '0;
        for (int k = 0; k < 16; k++) begin
            r[k] = d[15-k];
        end
        return r;
    endfunction

    // Internal samples are two's complement; offset binary flips the MSB
    function automatic logic [15:0] to_twos(input logic [15:0] d,
                                            input logic        offs);
        return {d[15] ^ offs, d[14:0]};
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] cfg_ff;
    logic [7:0] taps_ff;
    logic [7:0] trim_ff;
    logic [7:0] setup_ff;
    logic [7:0] rdata_ff;

    wire hit_cfg   = (reg_addr == lsip_pkg::ADDR_CFG);
    wire hit_taps  = (reg_addr == lsip_pkg::ADDR_TAPS);
    wire hit_trim  = (reg_addr == lsip_pkg::ADDR_TRIM);
    wire hit_setup = (reg_addr == lsip_pkg::ADDR_SETUP);

    logic [7:0] nxt_rdata;
    assign nxt_rdata = hit_cfg   ? cfg_ff   :
                       hit_taps  ? taps_ff  :
                       hit_trim  ? trim_ff  :
                       hit_setup ? setup_ff : 8'h00;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff   <= lsip_pkg::RST_CFG;
            taps_ff  <= lsip_pkg::RST_TAPS;
            trim_ff  <= lsip_pkg::RST_TRIM;
            setup_ff <= lsip_pkg::RST_SETUP;
            rdata_ff <= 8'h00;
        end else begin
            if (reg_wr && hit_cfg)
                cfg_ff <= reg_wdata;
            if (reg_wr && hit_taps)
                taps_ff <= reg_wdata;
            if (reg_wr && hit_trim)
                trim_ff <= reg_wdata;
            if (reg_wr && hit_setup)
                setup_ff <= reg_wdata;
            if (reg_rd)
                rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    wire byte_mode = cfg_ff[lsip_pkg::CFG_BYTE_BIT];
    wire bus_inv   = cfg_ff[lsip_pkg::CFG_INV_BIT];
    wire pair_late = cfg_ff[lsip_pkg::CFG_PAIR_BIT];
    wire fmt_offs  = cfg_ff[lsip_pkg::CFG_FMT_BIT];
    wire dly_en    = trim_ff[lsip_pkg::TRIM_EN_BIT];

    // ------------------------------------------------------------------
    // Delay setting decode
    // ------------------------------------------------------------------
    // Unlisted tap/trim pairs fall back to setting 0
    wire [2:0] trim_lo = trim_ff[2:0];
    wire set3 = (taps_ff == lsip_pkg::TAPS_SET3) &&
                (trim_lo == lsip_pkg::TRIM_SET3);
    wire set2 = (taps_ff == lsip_pkg::TAPS_SET2) &&
                (trim_lo == lsip_pkg::TRIM_SET012);
    wire set1 = (taps_ff == lsip_pkg::TAPS_SET1) &&
                (trim_lo == lsip_pkg::TRIM_SET012);
    wire [1:0] dly_sel = set3 ? 2'h3 : set2 ? 2'h2 :
                         set1 ? 2'h1 : 2'h0;

    assign delay_setting = dly_sel;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [15:0] bus_s1_ff;
    logic [15:0] bus_s2_ff;
    logic        frm_s1_ff;
    logic        frm_s2_ff;
    logic        clk_s1_ff;
    logic        clk_s2_ff;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_s1_ff <= 16'h0000;
            bus_s2_ff <= 16'h0000;
            frm_s1_ff <= 1'b0;
            frm_s2_ff <= 1'b0;
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
        end else begin
            bus_s1_ff <= sample_bus_lines;
            bus_s2_ff <= bus_s1_ff;
            frm_s1_ff <= frame_in;
            frm_s2_ff <= frm_s1_ff;
            clk_s1_ff <= forwarded_data_clock;
            clk_s2_ff <= clk_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Clock delay line
    // ------------------------------------------------------------------
    // Only the sampled clock is delayed, moving the sample point later
    // against the data, as the analog line would.
    localparam int DLY_N = lsip_pkg::DLY_MAX_CYC;
    logic [DLY_N:1] clk_hist_ff;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            clk_hist_ff <= '0;
        else
            clk_hist_ff <= {clk_hist_ff[DLY_N-1:1], clk_s2_ff};
    end

    int dly_idx;
    assign dly_idx = lsip_pkg::FIX_DLY_CYC +
                     int'(dly_sel) * lsip_pkg::TAP_DLY_CYC;

    wire clk_view = dly_en ? clk_hist_ff[dly_idx] : clk_s2_ff;

    logic clk_prev_ff;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            clk_prev_ff <= 1'b0;
        else
            clk_prev_ff <= clk_view;
    end

    wire edge_rise = clk_view & ~clk_prev_ff;
    wire edge_fall = ~clk_view & clk_prev_ff;
    wire edge_any  = edge_rise | edge_fall;

    // ------------------------------------------------------------------
    // Capture of the bus at each clock edge
    // ------------------------------------------------------------------
    wire [15:0] bus_ord = bus_inv ? rev16(bus_s2_ff) : bus_s2_ff;
    wire [7:0]  bus_byte = bus_ord[7:0];

    // Frame level seen at the previous clock edge
    logic frm_last_ff;
    wire  frm_rise = edge_any & frm_s2_ff & ~frm_last_ff;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            frm_last_ff <= 1'b0;
        else if (edge_any)
            frm_last_ff <= frm_s2_ff;
    end

    // ------------------------------------------------------------------
    // Byte sequencer
    // ------------------------------------------------------------------
    lsip_pkg::lsip_byte_t byte_ff;
    lsip_pkg::lsip_byte_t nxt_byte;
    lsip_pkg::lsip_byte_t cur_byte;
    logic                 aligned_ff;

    // A frame rise names the byte on the bus as the in-phase high byte
    assign cur_byte = frm_rise ? lsip_pkg::BYTE_I_HI : byte_ff;

    always_comb begin
        unique case (cur_byte)
            lsip_pkg::BYTE_I_HI: nxt_byte = lsip_pkg::BYTE_I_LO;
            lsip_pkg::BYTE_I_LO: nxt_byte = lsip_pkg::BYTE_Q_HI;
            lsip_pkg::BYTE_Q_HI: nxt_byte = lsip_pkg::BYTE_Q_LO;
            lsip_pkg::BYTE_Q_LO: nxt_byte = lsip_pkg::BYTE_I_HI;
        endcase
    end

    wire byte_ok = byte_mode & edge_any & (aligned_ff | frm_rise);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            byte_ff    <= lsip_pkg::BYTE_I_HI;
            aligned_ff <= 1'b0;
        end else if (!byte_mode) begin
            aligned_ff <= 1'b0;
        end else if (edge_any) begin
            if (frm_rise)
                aligned_ff <= 1'b1;
            byte_ff <= nxt_byte;
        end
    end

    assign frame_aligned = aligned_ff;

    // ------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------
    logic [7:0]  i_hi_ff;
    logic [7:0]  q_hi_ff;
    logic [15:0] i_word_ff;
    logic [15:0] q_word_ff;
    logic        q_seen_ff;

    wire b_ih = byte_ok && (cur_byte == lsip_pkg::BYTE_I_HI);
    wire b_il = byte_ok && (cur_byte == lsip_pkg::BYTE_I_LO);
    wire b_qh = byte_ok && (cur_byte == lsip_pkg::BYTE_Q_HI);
    wire b_ql = byte_ok && (cur_byte == lsip_pkg::BYTE_Q_LO);

    wire w_i = ~byte_mode & edge_rise;
    wire w_q = ~byte_mode & edge_fall;

    wire i_done = w_i | b_il;
    wire q_done = w_q | b_ql;

    wire [15:0] i_new = byte_mode ? {i_hi_ff, bus_byte} : bus_ord;
    wire [15:0] q_new = byte_mode ? {q_hi_ff, bus_byte} : bus_ord;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            i_hi_ff   <= 8'h00;
            q_hi_ff   <= 8'h00;
            i_word_ff <= 16'h0000;
            q_word_ff <= 16'h0000;
            q_seen_ff <= 1'b0;
        end else begin
            if (b_ih)
                i_hi_ff <= bus_byte;
            if (b_qh)
                q_hi_ff <= bus_byte;
            if (i_done)
                i_word_ff <= i_new;
            if (q_done) begin
                q_word_ff <= q_new;
                q_seen_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pairing and formatting
    // ------------------------------------------------------------------
    // Default: a pair closes on the quadrature word with the last I.
    // Late pairing: closes on the I word with the previous Q word.
    wire emit_early = ~pair_late & q_done;
    wire emit_late  = pair_late & i_done & q_seen_ff;
    wire emit       = emit_early | emit_late;

    wire [15:0] pair_i_raw = emit_late  ? i_new : i_word_ff;
    wire [15:0] pair_q_raw = emit_early ? q_new : q_word_ff;

    logic [15:0] pair_i_ff;
    logic [15:0] pair_q_ff;
    logic        pend_ff;
    logic        drop_ff;
    logic        fifo_ready;

    // A pair waiting on a full FIFO holds; a newer pair is then lost,
    // since the link itself cannot be stalled.
    wire load = emit & (~pend_ff | fifo_ready);
    wire lost = emit & pend_ff & ~fifo_ready;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pair_i_ff <= 16'h0000;
            pair_q_ff <= 16'h0000;
            pend_ff   <= 1'b0;
            drop_ff   <= 1'b0;
        end else begin
            if (load) begin
                pair_i_ff <= to_twos(pair_i_raw, fmt_offs);
                pair_q_ff <= to_twos(pair_q_raw, fmt_offs);
            end
            if (load)
                pend_ff <= 1'b1;
            else if (fifo_ready)
                pend_ff <= 1'b0;
            if (lost)
                drop_ff <= 1'b1;
        end
    end

    assign pair_dropped = drop_ff;

    // ------------------------------------------------------------------
    // Buffer toward the converter side
    // ------------------------------------------------------------------
    logic [31:0] fifo_out;

    lsip_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (pend_ff),
        .in_ready  (fifo_ready),
        .in_data   ({pair_i_ff, pair_q_ff}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out)
    );

    assign out_i = fifo_out[31:16];
    assign out_q = fifo_out[15:0];

endmodule
`default_nettype wire

// file: test/lsip_port_checker.sv
// Assertion checker for the sample input port
`timescale 1ns/1ps
`default_nettype none
module lsip_port_checker #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [15:0] sample_bus_lines,
    input wire logic        frame_in,
    input wire logic        forwarded_data_clock,
    input wire logic [14:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [15:0] out_i,
    input wire logic [15:0] out_q,
    input wire logic        frame_aligned,
    input wire logic        pair_dropped,
    input wire logic [1:0]  delay_setting
);
    // ------------------------------------------------------------
    // Register shadows
    // ------------------------------------------------------------
    logic [7:0] cfg_ff;
    logic [7:0] taps_ff;
    logic [7:0] trim_ff;
    wire logic  sel_cfg  = reg_addr == lsip_pkg::ADDR_CFG;
    wire logic  sel_taps = reg_addr == lsip_pkg::ADDR_TAPS;
    wire logic  sel_trim = reg_addr == lsip_pkg::ADDR_TRIM;
    wire logic  t_zero   = trim_ff[2:0] == lsip_pkg::TRIM_SET012;
    wire logic [1:0] exp_dly =
        (taps_ff == lsip_pkg::TAPS_SET3
         && trim_ff[2:0] == lsip_pkg::TRIM_SET3) ? 2'h3 :
        (taps_ff == lsip_pkg::TAPS_SET2 && t_zero) ? 2'h2 :
        (taps_ff == lsip_pkg::TAPS_SET1 && t_zero) ? 2'h1 : 2'h0;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff  <= 8'h00;
            taps_ff <= 8'h00;
            trim_ff <= 8'h00;
        end else if (reg_wr) begin
            if (sel_cfg) cfg_ff <= reg_wdata;
            if (sel_taps) taps_ff <= reg_wdata;
            if (sel_trim) trim_ff <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_rd_cfg;
        reg_rd && !reg_wr && sel_cfg;
    endsequence
    sequence s_rd_trim;
        reg_rd && !reg_wr && sel_trim;
    endsequence
    sequence s_word_steady;
        !cfg_ff[0] [*3];
    endsequence

    a_cfg_readback: assert property (s_rd_cfg |=> reg_rdata == cfg_ff)
        else $error("config readback differs from last write");
    a_trim_readback: assert property (s_rd_trim |=> reg_rdata == trim_ff)
        else $error("trim readback differs from last write");
    a_delay_decode: assert property (delay_setting == exp_dly)
        else $error("delay setting does not match tap and trim values");
    a_word_no_align: assert property (s_word_steady |-> !frame_aligned)
        else $error("alignment held outside byte mode");
    a_align_cause: assert property ($rose(frame_aligned) |-> frame_in && cfg_ff[0])
        else $error("alignment without frame in byte mode");
    a_head_holds: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_i) && $stable(out_q))
        else $error("fifo head changed while not accepted");
    a_drop_sticky: assert property (pair_dropped |=> pair_dropped)
        else $error("drop flag cleared without reset");
    a_drop_when_full: assert property ($rose(pair_dropped) |-> out_valid)
        else $error("pair dropped while fifo empty");
endmodule

bind lsip_port lsip_port_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .frame_in(frame_in),
    .sample_bus_lines(sample_bus_lines), .reg_addr(reg_addr),
    .forwarded_data_clock(forwarded_data_clock), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i),
    .out_q(out_q), .frame_aligned(frame_aligned),
    .pair_dropped(pair_dropped), .delay_setting(delay_setting));
`default_nettype wire

// file: test/lsip_src_model.sv
// Behavioural sample source driving the link side of the port
`timescale 1ns/1ps
`default_nettype none
module lsip_src_model (
    output var logic        forwarded_data_clock,
    output var logic [15:0] sample_bus_lines,
    output var logic        frame_in
);
    initial begin
        forwarded_data_clock = 1'b0;
        sample_bus_lines     = 16'h0000;
        frame_in             = 1'b0;
    end

    // Long hold after each edge covers the widest delay-line setting
    task automatic edge_out(input logic [15:0] d, input logic f);
        sample_bus_lines <= d;
        frame_in         <= f;
        #22;
        forwarded_data_clock <= ~forwarded_data_clock;
        #40.5;
    endtask

    task automatic word_pair(input logic [15:0] i, input logic [15:0] q);
        edge_out(i, 1'b0);
        edge_out(q, 1'b0);
    endtask

    // Frame high over two edges, one full clock period
    task automatic byte_pair(input logic [15:0] i, input logic [15:0] q,
                             input logic f);
        edge_out({8'hA5, i[15:8]}, f);
        edge_out({8'h5A, i[7:0]}, f);
        edge_out({8'hC3, q[15:8]}, 1'b0);
        edge_out({8'h3C, q[7:0]}, 1'b0);
    endtask

    // Clock stands still; idle bus shows no stale value
    task automatic rest();
        sample_bus_lines <= ~sample_bus_lines;
        frame_in         <= 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// file: test/lsip_port_bench.sv
// Self-checking bench for the sample input port
`timescale 1ns/1ps
`default_nettype none
module lsip_port_bench;
    logic        clk_sys;
    logic        sys_rst;
    logic [14:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic        out_ready;
    wire  [15:0] bus;
    wire         frm;
    wire         lclk;
    wire  [7:0]  reg_rdata;
    wire         out_valid;
    wire  [15:0] out_i;
    wire  [15:0] out_q;
    wire         frame_aligned;
    wire         pair_dropped;
    wire  [1:0]  delay_setting;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cyc_count  = 0;
    logic [14:0] adr [4];
    logic [7:0]  tp [4];
    logic [2:0]  tr [4];

    lsip_port #(.FIFO_DEPTH(32)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sample_bus_lines(bus),
        .frame_in(frm), .forwarded_data_clock(lclk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .out_valid(out_valid), .out_ready(out_ready),
        .out_i(out_i), .out_q(out_q), .frame_aligned(frame_aligned),
        .pair_dropped(pair_dropped), .delay_setting(delay_setting));
    lsip_src_model i_src (.forwarded_data_clock(lclk),
        .sample_bus_lines(bus), .frame_in(frm));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic pop(input logic [15:0] ei, input logic [15:0] eq);
        int n = 0;
        #1;
        while (out_valid !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(out_i, ei);
        check(out_q, eq);
        @(posedge clk_sys);
        out_ready <= 1'b1;
        @(posedge clk_sys);
        out_ready <= 1'b0;
    endtask
    task automatic quiet();
        repeat (40) @(posedge clk_sys);
        #1;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence of tests
    // ------------------------------------------------------------
    initial begin
        sys_rst   = 1'b1;
        reg_addr  = 15'h0000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        out_ready = 1'b0;
        adr = '{lsip_pkg::ADDR_CFG, lsip_pkg::ADDR_TAPS,
                lsip_pkg::ADDR_TRIM, lsip_pkg::ADDR_SETUP};
        tp  = '{8'h00, 8'h07, 8'h7F, 8'hFF};
        tr  = '{3'h0, 3'h0, 3'h0, 3'h5};
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            rdchk(adr[k], 8'h00);
            wr(adr[k], 8'h5A + 8'(k));
            rdchk(adr[k], 8'h5A + 8'(k));
        end
        wr(15'h0027, 8'hFF);
        rdchk(15'h0027, 8'h00);
        wr(lsip_pkg::ADDR_SETUP, 8'h18);
        wr(lsip_pkg::ADDR_TAPS, 8'h00);
        wr(lsip_pkg::ADDR_TRIM, 8'h00);
        wr(lsip_pkg::ADDR_TRIM, 8'h08);
        rdchk(lsip_pkg::ADDR_TRIM, 8'h08);
        wr(lsip_pkg::ADDR_CFG, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(lsip_pkg::ADDR_TAPS, tp[s]);
            wr(lsip_pkg::ADDR_TRIM, {5'h01, tr[s]});
            #1;
            check(16'(delay_setting), 16'(s));
            i_src.word_pair(16'h1000 + 16'(s), 16'hE000 + 16'(s));
            pop(16'h1000 + 16'(s), 16'hE000 + 16'(s));
        end
        wr(lsip_pkg::ADDR_CFG, 8'h80);
        i_src.word_pair(16'h1234, 16'h8001);
        pop(16'h9234, 16'h0001);
        wr(lsip_pkg::ADDR_CFG, 8'h20);
        i_src.word_pair(16'h0001, 16'h00F0);
        pop(16'h8000, 16'h0F00);
        // Second reset clears pairing history
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        wr(lsip_pkg::ADDR_CFG, 8'h40);
        i_src.word_pair(16'h1111, 16'h2222);
        i_src.word_pair(16'h3333, 16'h4444);
        pop(16'h3333, 16'h2222);
        quiet();
        check(16'(out_valid), 16'h0000);
        wr(lsip_pkg::ADDR_CFG, 8'h01);
        i_src.byte_pair(16'hAAAA, 16'hBBBB, 1'b0);
        i_src.rest();
        quiet();
        check(16'(out_valid), 16'h0000);
        check(16'(frame_aligned), 16'h0000);
        i_src.byte_pair(16'h1234, 16'h5678, 1'b1);
        i_src.byte_pair(16'h9ABC, 16'hDEF0, 1'b0);
        i_src.rest();
        pop(16'h1234, 16'h5678);
        pop(16'h9ABC, 16'hDEF0);
        check(16'(frame_aligned), 16'h0001);
        i_src.byte_pair(16'h0F1E, 16'h2D3C, 1'b1);
        i_src.byte_pair(16'h4B5A, 16'h6978, 1'b1);
        i_src.rest();
        pop(16'h0F1E, 16'h2D3C);
        pop(16'h4B5A, 16'h6978);
        wr(lsip_pkg::ADDR_CFG, 8'h00);
        quiet();
        check(16'(frame_aligned), 16'h0000);
        check(16'(pair_dropped), 16'h0000);
        for (int k = 0; k < 35; k++) begin
            i_src.word_pair(16'h0100 + 16'(k), 16'hF000 + 16'(k));
        end
        i_src.rest();
        quiet();
        check(16'(pair_dropped), 16'h0001);
        for (int k = 0; k < 33; k++) begin
            pop(16'h0100 + 16'(k), 16'hF000 + 16'(k));
        end
        quiet();
        check(16'(out_valid), 16'h0000);
        close_out();
    end
endmodule
`default_nettype wire
